/* rtl/imlu_top.sv */
// interrupt mask, latch and output pin logic of the audio converter
//
// Operation
// - with behaviour zero the pin is active while any unmasked flag is set.
// - with behaviour two the pin pulses 2 ms in every 4 ms while pending.
// - with behaviour three each unmasked event starts a 2 ms pulse, restarting one in progress.
// - with the readback filter clear every latched flag reads back.
// - with the readback filter set only unmasked flags read back.
// - the mask register resets to all ones, masking every source.
// - mask bit 7 gates the serial interface clock error source.
// - mask bit 6 gates the PLL lock event source.
// - flag bit 7 latches a serial interface clock error and clears on read.
// - flag bit 6 latches a PLL lock event and clears on read.
// - the flag register is read-only, resets to zero, low bits read zero.
// - the polarity bit picks active-low at zero, active-high at one.
`timescale 1ns/1ps
module imlu_top #(
    parameter int PULSE_CYC  = imlu_pkg::IMLU_PULSE_CYC,
    parameter int PERIOD_CYC = imlu_pkg::IMLU_PERIOD_CYC,
    parameter int CNT_W      = imlu_pkg::IMLU_CNT_W
) (
    input  wire logic       CLOCK_I,
    input  wire logic       RESET_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    input  wire logic       SIF_CLK_ERR_I,
    input  wire logic       PLL_LOCK_I,
    output logic      [7:0] REG_RDATA_O,
    output logic            IRQ_PIN_O
);

    // configuration fields, flag, read data and pin state
    logic                  cfg_pol_reg;
    logic [1:0]            cfg_event_reg;
    logic                  cfg_filter_reg;
    logic [7:0]            mask_reg;
    logic [1:0]            flags_reg;
    logic [1:0]            flags_next;
    logic [7:0]            rdata_reg;
    logic [7:0]            rdata_next;
    logic                  irq_pin_reg;

    // decode and derived terms
    logic                  wr_cfg;
    logic                  wr_mask;
    logic                  rd_ltch;
    logic [1:0]            src_evt;
    logic [1:0]            src_mask;
    logic [1:0]            flags_view;
    logic                  pending;
    logic                  new_unmasked;
    imlu_pkg::imlu_evt_type evt_mode;
    logic                  level_mode;
    logic                  tmr_start;
    logic                  tmr_clear;
    logic                  tmr_repeat;
    logic                  tmr_busy;
    logic                  tmr_active;
    logic                  irq_active;

    // register port decode
    assign wr_cfg  = REG_WR_I && (REG_ADDR_I == imlu_pkg::IMLU_OFS_CFG);
    assign wr_mask = REG_WR_I && (REG_ADDR_I == imlu_pkg::IMLU_OFS_MASK);
    assign rd_ltch = REG_RD_I && (REG_ADDR_I == imlu_pkg::IMLU_OFS_LTCH);

    // sources ordered as {serial clock error, pll lock}
    assign src_evt  = {SIF_CLK_ERR_I, PLL_LOCK_I};
    assign src_mask = {mask_reg[imlu_pkg::IMLU_SRC_SIF_BIT],
                       mask_reg[imlu_pkg::IMLU_SRC_PLL_BIT]};

    // configuration register, reserved bits not stored
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            cfg_pol_reg    <= imlu_pkg::IMLU_CFG_RESET[7];
            cfg_event_reg  <= imlu_pkg::IMLU_CFG_RESET[6:5];
            cfg_filter_reg <= imlu_pkg::IMLU_CFG_RESET[2];
        end else if (wr_cfg) begin
            cfg_pol_reg    <= REG_WDATA_I[imlu_pkg::IMLU_CFG_POL_BIT];
            cfg_event_reg  <= REG_WDATA_I[imlu_pkg::IMLU_CFG_EVT_HI:
                                          imlu_pkg::IMLU_CFG_EVT_LO];
            cfg_filter_reg <= REG_WDATA_I[imlu_pkg::IMLU_CFG_FILT_BIT];
        end
    end

    // mask register, all eight bits writable
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            mask_reg <= imlu_pkg::IMLU_MASK_RESET;
        end else if (wr_mask) begin
            mask_reg <= REG_WDATA_I;
        end
    end

    // latched flags: cleared by a read, a new event always wins
    always_comb begin
        flags_next = rd_ltch ? 2'h0 : flags_reg;
        flags_next = flags_next | src_evt;
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            flags_reg <= imlu_pkg::IMLU_LTCH_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // readback view of the flags
    assign flags_view = cfg_filter_reg ? (flags_reg & ~src_mask)
                                       : flags_reg;

    // read data mux, unmapped offsets read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                imlu_pkg::IMLU_OFS_CFG: begin
                    rdata_next = {cfg_pol_reg, cfg_event_reg,
                                  2'h0, cfg_filter_reg, 2'h0};
                end
                imlu_pkg::IMLU_OFS_MASK: begin
                    rdata_next = mask_reg;
                end
                imlu_pkg::IMLU_OFS_LTCH: begin
                    rdata_next = {flags_view, 6'h00};
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            rdata_reg <= imlu_pkg::IMLU_RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // pending and new unmasked events
    assign pending      = |(flags_reg & ~src_mask);
    assign new_unmasked = |(src_evt & ~src_mask);

    // output behaviour selection
    assign evt_mode   = imlu_pkg::imlu_evt_type'(cfg_event_reg);
    assign level_mode = (evt_mode == imlu_pkg::IMLU_EVT_LEVEL)
                     || (evt_mode == imlu_pkg::IMLU_EVT_RSVD);

    // timer control per behaviour
    always_comb begin
        tmr_start  = 1'b0;
        tmr_clear  = 1'b1;
        tmr_repeat = 1'b0;
        case (evt_mode)
            imlu_pkg::IMLU_EVT_REPEAT: begin
                tmr_repeat = 1'b1;
                tmr_clear  = !pending;
                tmr_start  = pending && !tmr_busy;
            end
            imlu_pkg::IMLU_EVT_ONCE: begin
                tmr_clear  = 1'b0;
                tmr_start  = new_unmasked;
            end
            default: begin
                tmr_clear  = 1'b1;
            end
        endcase
    end

    imlu_pulse_timer #(
        .PULSE_CYC  (PULSE_CYC),
        .PERIOD_CYC (PERIOD_CYC),
        .CNT_W      (CNT_W)
    ) u_timer (
        .clk_i    (CLOCK_I),
        .rst_i    (RESET_I),
        .start_i  (tmr_start),
        .clear_i  (tmr_clear),
        .repeat_i (tmr_repeat),
        .busy_o   (tmr_busy),
        .active_o (tmr_active)
    );

    assign irq_active = level_mode ? pending : tmr_active;

    // output pin with selectable polarity
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            irq_pin_reg <= 1'b1; // inactive for the reset polarity
        end else begin
            irq_pin_reg <= irq_active ~^ cfg_pol_reg;
        end
    end

    assign REG_RDATA_O = rdata_reg;
    assign IRQ_PIN_O   = irq_pin_reg;

    property p_level_out;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (cfg_event_reg == 2'h0)
        |=> (IRQ_PIN_O == ($past(pending) ~^ $past(cfg_pol_reg)));
    endproperty
    a_level_out: assert property (p_level_out)
        else $error("level pin does not follow pending flags");

    property p_rsvd_level;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (cfg_event_reg == 2'h1 && pending && cfg_pol_reg)
        |=> IRQ_PIN_O;
    endproperty
    a_rsvd_level: assert property (p_rsvd_level)
        else $error("reserved behaviour is not level behaviour");

    property p_repeat_start;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (cfg_event_reg == 2'h2 && pending && !tmr_busy)
        ##1 (cfg_event_reg == 2'h2) |=> (IRQ_PIN_O == $past(cfg_pol_reg));
    endproperty
    a_repeat_start: assert property (p_repeat_start)
        else $error("repeat pulse did not start on pending flag");

    property p_once_start;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (cfg_event_reg == 2'h3 && new_unmasked)
        ##1 (cfg_event_reg == 2'h3) |=> (IRQ_PIN_O == $past(cfg_pol_reg));
    endproperty
    a_once_start: assert property (p_once_start)
        else $error("one-shot pulse did not start on event");

    property p_read_all;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (rd_ltch && !cfg_filter_reg)
        |=> (REG_RDATA_O[7:6] == $past(flags_reg));
    endproperty
    a_read_all: assert property (p_read_all)
        else $error("unfiltered readback differs from flags");

    property p_read_unmasked;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (rd_ltch && cfg_filter_reg)
        |=> (REG_RDATA_O[7:6] == ($past(flags_reg) & ~$past(src_mask)));
    endproperty
    a_read_unmasked: assert property (p_read_unmasked)
        else $error("filtered readback shows a masked flag");

    property p_mask_reset;
        @(posedge CLOCK_I)
        RESET_I |=> (mask_reg == imlu_pkg::IMLU_MASK_RESET);
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("mask register not all ones after reset");

    property p_sif_masked;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (!cfg_event_reg[1] && mask_reg[7]
            && !(flags_reg[0] && !mask_reg[6]))
        |=> (IRQ_PIN_O != $past(cfg_pol_reg));
    endproperty
    a_sif_masked: assert property (p_sif_masked)
        else $error("masked clock error flag still drives the pin");

    property p_pll_unmasked;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (!cfg_event_reg[1] && !mask_reg[6] && flags_reg[0])
        |=> (IRQ_PIN_O == $past(cfg_pol_reg));
    endproperty
    a_pll_unmasked: assert property (p_pll_unmasked)
        else $error("unmasked pll flag does not drive the pin");

    property p_sif_latch;
        @(posedge CLOCK_I) disable iff (RESET_I)
        SIF_CLK_ERR_I |=> flags_reg[1];
    endproperty
    a_sif_latch: assert property (p_sif_latch)
        else $error("clock error event not latched");

    property p_pll_latch;
        @(posedge CLOCK_I) disable iff (RESET_I)
        PLL_LOCK_I |=> flags_reg[0];
    endproperty
    a_pll_latch: assert property (p_pll_latch)
        else $error("pll lock event not latched");

    property p_low_bits;
        @(posedge CLOCK_I) disable iff (RESET_I)
        rd_ltch |=> (REG_RDATA_O[5:0] == 6'h00);
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("unused flag bits read nonzero");

    property p_pol_low;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (!cfg_pol_reg && irq_active) |=> !IRQ_PIN_O;
    endproperty
    a_pol_low: assert property (p_pol_low)
        else $error("active-low pin not driven low when active");

    property p_read_clear;
        @(posedge CLOCK_I) disable iff (RESET_I)
        (rd_ltch && !SIF_CLK_ERR_I && !PLL_LOCK_I) |=> (flags_reg == 2'h0);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("flags not cleared by read");

endmodule

/* rtl/imlu_pkg.sv */
// constants and types of the interrupt mask and latch unit
package imlu_pkg;

    // register offsets on the control port
    localparam logic [7:0] IMLU_OFS_CFG  = 8'h32;
    localparam logic [7:0] IMLU_OFS_MASK = 8'h33;
    localparam logic [7:0] IMLU_OFS_LTCH = 8'h36;

    // values after reset
    localparam logic [7:0] IMLU_CFG_RESET  = 8'h00;
    localparam logic [7:0] IMLU_MASK_RESET = 8'hFF;
    localparam logic [1:0] IMLU_LTCH_RESET = 2'h0;
    localparam logic [7:0] IMLU_RDATA_RESET = 8'h00;

    // field positions in the configuration register
    localparam int IMLU_CFG_POL_BIT  = 7;
    localparam int IMLU_CFG_EVT_HI   = 6;
    localparam int IMLU_CFG_EVT_LO   = 5;
    localparam int IMLU_CFG_FILT_BIT = 2;

    // source positions in mask and latched flag registers
    localparam int IMLU_SRC_SIF_BIT = 7;
    localparam int IMLU_SRC_PLL_BIT = 6;

    // pulse timing: 2 ms on, 4 ms period, 200 MHz clock
    localparam int IMLU_CLK_MHZ        = 200;
    localparam int IMLU_PULSE_TIME_US  = 2000;
    localparam int IMLU_PERIOD_TIME_US = 4000;
    localparam int IMLU_PULSE_CYC  = IMLU_PULSE_TIME_US * IMLU_CLK_MHZ;
    localparam int IMLU_PERIOD_CYC = IMLU_PERIOD_TIME_US * IMLU_CLK_MHZ;
    localparam int IMLU_CNT_W      = 20;

    // behaviour of the interrupt output
    typedef enum logic [1:0] {
        IMLU_EVT_LEVEL  = 2'h0,
        IMLU_EVT_RSVD   = 2'h1,
        IMLU_EVT_REPEAT = 2'h2,
        IMLU_EVT_ONCE   = 2'h3
    } imlu_evt_type;

endpackage

/* rtl/imlu_pulse_timer.sv */
// pulse timer for repeating and one-shot interrupt pulses
`timescale 1ns/1ps
module imlu_pulse_timer #(
    parameter int PULSE_CYC  = imlu_pkg::IMLU_PULSE_CYC,
    parameter int PERIOD_CYC = imlu_pkg::IMLU_PERIOD_CYC,
    parameter int CNT_W      = imlu_pkg::IMLU_CNT_W
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic clear_i,
    input  wire logic repeat_i,
    output logic      busy_o,
    output logic      active_o
);

    localparam logic [CNT_W-1:0] PULSE_LAST  = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LEN   = CNT_W'(PULSE_CYC);

    logic [CNT_W-1:0] cnt_reg;
    logic             run_reg;

    // cycle counter: restart, wrap on period, stop after one pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else if (start_i) begin
            cnt_reg <= '0;
            run_reg <= 1'b1;
        end else if (run_reg) begin
            if (repeat_i && cnt_reg == PERIOD_LAST) begin
                cnt_reg <= '0;
            end else if (!repeat_i && cnt_reg == PULSE_LAST) begin
                run_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // first pulse length of each period is the active part
    assign busy_o   = run_reg;
    assign active_o = run_reg && (cnt_reg < PULSE_LEN);

    property p_period_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (run_reg && repeat_i && cnt_reg == PERIOD_LAST
            && !start_i && !clear_i)
        |=> (run_reg && cnt_reg == '0 && active_o);
    endproperty
    a_period_wrap: assert property (p_period_wrap)
        else $error("repeat pulse did not restart after its period");

    property p_one_shot_end;
        @(posedge clk_i) disable iff (rst_i)
        (run_reg && !repeat_i && cnt_reg == PULSE_LAST
            && !start_i && !clear_i)
        |=> (!run_reg && !active_o);
    endproperty
    a_one_shot_end: assert property (p_one_shot_end)
        else $error("one-shot pulse did not end after its length");

endmodule

/* test/imlu_host_model.sv */
// host side model that decodes and counts interrupt pulses
`timescale 1ns/1ps
module imlu_host_model (
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire logic       pin_i,
    input  wire logic       pol_i,
    output logic            active_o,
    output logic      [7:0] pulses_o
);
    logic prev_reg;

    // active level follows the programmed polarity
    assign active_o = (pin_i == pol_i);

    // count every start of an active stretch
    always_ff @(posedge clk_i) begin
        prev_reg <= active_o;
        if (clr_i) begin
            pulses_o <= 8'h00;
        end else if (active_o && !prev_reg) begin
            pulses_o <= pulses_o + 8'h01;
        end
    end
endmodule

/* test/tb_irq_mask_latch_unit.sv */
// self-checking bench of the interrupt mask and latch unit
`timescale 1ns/1ps
module tb_irq_mask_latch_unit;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       sif = 1'b0;
    logic       pll = 1'b0;
    logic       pol = 1'b0;
    logic       clr = 1'b1;
    logic [7:0] rdata;
    logic       pin;
    logic       act;
    logic [7:0] pulses;
    int         n_mismatch = 0;
    int         samples_checked = 0;

    // short pulse timing keeps the run brief
    imlu_top #(.PULSE_CYC(8), .PERIOD_CYC(16), .CNT_W(20)) DUT (
        .CLOCK_I       (clk),
        .RESET_I       (rst),
        .REG_ADDR_I    (addr),
        .REG_WDATA_I   (wdata),
        .REG_WR_I      (wr),
        .REG_RD_I      (rd),
        .SIF_CLK_ERR_I (sif),
        .PLL_LOCK_I    (pll),
        .REG_RDATA_O   (rdata),
        .IRQ_PIN_O     (pin)
    );

    // host processor on the interrupt line
    imlu_host_model host (
        .clk_i    (clk),
        .clr_i    (clr),
        .pin_i    (pin),
        .pol_i    (pol),
        .active_o (act),
        .pulses_o (pulses)
    );

    // clock generation
    initial begin
        forever #2.5 clk = ~clk;
    end

    // verdict and end of run
    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // byte comparison
    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // pin state as seen by the host
    task automatic pin_chk(input logic e);
        chk("irq active", {7'h00, e}, {7'h00, act});
    endtask

    // one write cycle, then one idle cycle
    task automatic wr_reg(input logic [7:0] a, d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        if (a == 8'h32) begin
            pol = d[7];
        end
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask

    // one read cycle, data taken a cycle later
    task automatic rd_chk(input logic [7:0] a, e, input string nm);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk(nm, e, rdata);
    endtask

    // one-cycle event pulse on the chosen sources
    task automatic ev(input logic a, p);
        sif = a;
        pll = p;
        @(negedge clk);
        sif = 1'b0;
        pll = 1'b0;
        @(negedge clk);
    endtask

    // bounded wait for the host to see the pin active
    task automatic wait_act();
        int k;
        k = 0;
        while (act !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        if (act !== 1'b1) begin
            n_mismatch++;
            $display("Error irq active expected 1 seen %b", act);
            results();
        end
    endtask

    // values straight after reset
    task automatic t_reset();
        pin_chk(1'b0);
        rd_chk(8'h33, 8'hFF, "mask");
        rd_chk(8'h36, 8'h00, "flags");
        rd_chk(8'h32, 8'h00, "cfg");
        rd_chk(8'h40, 8'h00, "unmapped");
    endtask

    // read-only flags and reserved config bits
    task automatic t_regs();
        wr_reg(8'h36, 8'hFF);
        rd_chk(8'h36, 8'h00, "flags");
        wr_reg(8'h32, 8'hFF);
        rd_chk(8'h32, 8'hE4, "cfg");
        wr_reg(8'h33, 8'h5A);
        rd_chk(8'h33, 8'h5A, "mask");
    endtask

    // latching, masking and readback filter
    task automatic t_latch();
        wr_reg(8'h32, 8'h00);
        wr_reg(8'h33, 8'hFF);
        ev(1'b1, 1'b1);
        @(negedge clk);
        pin_chk(1'b0);
        rd_chk(8'h36, 8'hC0, "flags");
        rd_chk(8'h36, 8'h00, "flags");
        wr_reg(8'h32, 8'h04);
        wr_reg(8'h33, 8'h7F);
        ev(1'b1, 1'b1);
        @(negedge clk);
        pin_chk(1'b1);
        rd_chk(8'h36, 8'h80, "flags");
        @(negedge clk);
        pin_chk(1'b0);
    endtask

    // event in the same cycle as a clearing read
    task automatic t_race();
        wr_reg(8'h32, 8'h00);
        addr = 8'h36;
        rd = 1'b1;
        sif = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        sif = 1'b0;
        @(negedge clk);
        rd_chk(8'h36, 8'h80, "flags");
    endtask

    // level mode and reserved mode, each source alone
    task automatic t_level();
        for (int i = 0; i < 2; i++) begin
            wr_reg(8'h32, (i == 1) ? 8'hA0 : 8'h80);
            wr_reg(8'h33, (i == 1) ? 8'hBF : 8'h7F);
            ev(i == 0, i == 1);
            @(negedge clk);
            pin_chk(1'b1);
            repeat (40) @(negedge clk);
            pin_chk(1'b1);
            rd_chk(8'h36, (i == 1) ? 8'h40 : 8'h80, "flags");
            @(negedge clk);
            pin_chk(1'b0);
        end
    endtask

    // pulse modes: repeating while pending, or once
    task automatic t_pulse();
        int n;
        for (int i = 0; i < 2; i++) begin
            wr_reg(8'h32, (i == 1) ? 8'h60 : 8'h40);
            wr_reg(8'h33, 8'h7F);
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            ev(1'b1, 1'b0);
            wait_act();
            n = 0;
            repeat (48) begin
                n += int'(act);
                @(negedge clk);
            end
            chk("active cycles", (i == 1) ? 8'h08 : 8'h18, 8'(n));
            chk("pulses", (i == 1) ? 8'h01 : 8'h03, pulses);
            rd_chk(8'h36, 8'h80, "flags");
            repeat (2) @(negedge clk);
            pin_chk(1'b0);
        end
    endtask

    // reset, then the scenarios
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        clr = 1'b0;
        t_reset();
        t_regs();
        t_latch();
        t_race();
        t_level();
        t_pulse();
        results();
    end
endmodule
